// ### hdl/cbwd_window_decoder.sv
/*
 * Per-socket memory and I/O window registers with the primary cycle decoder.
 * Assumes configuration reads and writes arrive as one-cycle strobes on the
 * PCI clock, and that primary cycles are presented as one-cycle requests.
 */

// What this block does
// - Memory top holds address bits 31:12
// - Memory top low twelve bits read zero
// - Memory top compares with low bits ones
// - Equal memory bottom and top claims 4KB
// - Memory windows decode only with memory enable
// - I/O bottom bits 1:0 read 00
// - I/O forwarded only with address 31:16 zero
// - I/O bottom bits 15:2 set lower bound
// - I/O registers bits 31:16 read zero
// - I/O windows decode only with I/O enable
// - Equal I/O bottom and top claims doubleword
// - I/O top bits 15:2 set upper bound
// - I/O top bits 1:0 read 00
// - Memory bottom holds bits 31:12, low zero
module cbwd_window_decoder
	import cbwd_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	// Configuration access port
	input  wire logic        cfg_wr_in,
	input  wire logic        cfg_rd_in,
	input  wire logic [7:0]  cfg_addr_in,
	input  wire logic [3:0]  cfg_be_in,
	input  wire logic [31:0] cfg_wdata_in,
	output logic      [31:0] cfg_rdata_out,
	output logic             cfg_rvalid_out,
	// Primary cycle decode
	input  wire cbwd_req_s   req_in,
	output cbwd_ans_s        ans_out,
	output logic             ans_valid_out
);

	// Register state
	logic [31:0] cmd_reg,        cmd_next;
	logic [31:0] mem_bottom_reg [CBWD_NUM_WIN];
	logic [31:0] mem_bottom_next[CBWD_NUM_WIN];
	logic [31:0] mem_top_reg    [CBWD_NUM_WIN];
	logic [31:0] mem_top_next   [CBWD_NUM_WIN];
	logic [31:0] io_bottom_reg  [CBWD_NUM_WIN];
	logic [31:0] io_bottom_next [CBWD_NUM_WIN];
	logic [31:0] io_top_reg     [CBWD_NUM_WIN];
	logic [31:0] io_top_next    [CBWD_NUM_WIN];
	logic [31:0] rdata_reg,      rdata_next;
	logic        rvalid_reg,     rvalid_next;
	cbwd_ans_s   ans_reg,        ans_next;
	logic        avalid_reg,     avalid_next;

	// Decode hit per window
	logic        mem_hit[CBWD_NUM_WIN];
	logic        io_hit [CBWD_NUM_WIN];
	logic        mem_en;
	logic        io_en;
	logic        io_addr_ok;

	assign mem_en     = cmd_reg[CBWD_CMD_MEM_EN_BIT];
	assign io_en      = cmd_reg[CBWD_CMD_IO_EN_BIT];
	// Only 16-bit I/O decode is supported, so upper address must be zero
	assign io_addr_ok = (req_in.addr & CBWD_IO_HIGH_MASK) == 32'h0000_0000;

	// Window comparators, one pair per socket window
	for (genvar w = 0; w < CBWD_NUM_WIN; w++) begin : g_win
		logic [31:0] mem_top_eff;
		logic [15:0] io_top_eff;
		// Low page bits taken as ones so the page itself is included
		assign mem_top_eff = mem_top_reg[w] | CBWD_MEM_TOP_ONES;
		// Final doubleword is included in the I/O range
		assign io_top_eff  = io_top_reg[w][15:0] | CBWD_IO_TOP_ONES;
		// A top below the bottom naturally never matches, which disables it
		assign mem_hit[w] = mem_en && !req_in.is_io
			&& (req_in.addr >= mem_bottom_reg[w])
			&& (req_in.addr <= mem_top_eff);
		assign io_hit[w]  = io_en && req_in.is_io && io_addr_ok
			&& (req_in.addr[15:0] >= io_bottom_reg[w][15:0])
			&& (req_in.addr[15:0] <= io_top_eff);
	end

	// Next register values from configuration writes
	always_comb begin
		cmd_next = cmd_reg;
		for (int w = 0; w < CBWD_NUM_WIN; w++) begin
			mem_bottom_next[w] = mem_bottom_reg[w];
			mem_top_next[w]    = mem_top_reg[w];
			io_bottom_next[w]  = io_bottom_reg[w];
			io_top_next[w]     = io_top_reg[w];
		end
		if (cfg_wr_in) begin
			if (cfg_addr_in == CBWD_OFS_COMMAND) begin
				cmd_next = cbwd_merge(cmd_reg, cfg_wdata_in, cfg_be_in, CBWD_CMD_WMASK);
			end else if (cfg_addr_in == CBWD_OFS_MEM0_BOTTOM) begin
				mem_bottom_next[0] = cbwd_merge(mem_bottom_reg[0], cfg_wdata_in,
					cfg_be_in, CBWD_MEM_WMASK);
			end else if (cfg_addr_in == CBWD_OFS_MEM1_BOTTOM) begin
				mem_bottom_next[1] = cbwd_merge(mem_bottom_reg[1], cfg_wdata_in,
					cfg_be_in, CBWD_MEM_WMASK);
			end else if (cfg_addr_in == CBWD_OFS_MEM0_TOP) begin
				mem_top_next[0] = cbwd_merge(mem_top_reg[0], cfg_wdata_in,
					cfg_be_in, CBWD_MEM_WMASK);
			end else if (cfg_addr_in == CBWD_OFS_MEM1_TOP) begin
				mem_top_next[1] = cbwd_merge(mem_top_reg[1], cfg_wdata_in,
					cfg_be_in, CBWD_MEM_WMASK);
			end else if (cfg_addr_in == CBWD_OFS_IO0_BOTTOM) begin
				io_bottom_next[0] = cbwd_merge(io_bottom_reg[0], cfg_wdata_in,
					cfg_be_in, CBWD_IO_WMASK);
			end else if (cfg_addr_in == CBWD_OFS_IO1_BOTTOM) begin
				io_bottom_next[1] = cbwd_merge(io_bottom_reg[1], cfg_wdata_in,
					cfg_be_in, CBWD_IO_WMASK);
			end else if (cfg_addr_in == CBWD_OFS_IO0_TOP) begin
				io_top_next[0] = cbwd_merge(io_top_reg[0], cfg_wdata_in,
					cfg_be_in, CBWD_IO_WMASK);
			end else if (cfg_addr_in == CBWD_OFS_IO1_TOP) begin
				io_top_next[1] = cbwd_merge(io_top_reg[1], cfg_wdata_in,
					cfg_be_in, CBWD_IO_WMASK);
			end
		end
	end

	// Register storage; read-only bits never leave their reset zeros
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_reg <= CBWD_CMD_RST;
			for (int w = 0; w < CBWD_NUM_WIN; w++) begin
				mem_bottom_reg[w] <= CBWD_MEM_BOTTOM_RST;
				mem_top_reg[w]    <= CBWD_MEM_TOP_RST;
				io_bottom_reg[w]  <= CBWD_IO_BOTTOM_RST;
				io_top_reg[w]     <= CBWD_IO_TOP_RST;
			end
		end else begin
			cmd_reg <= cmd_next;
			for (int w = 0; w < CBWD_NUM_WIN; w++) begin
				mem_bottom_reg[w] <= mem_bottom_next[w];
				mem_top_reg[w]    <= mem_top_next[w];
				io_bottom_reg[w]  <= io_bottom_next[w];
				io_top_reg[w]     <= io_top_next[w];
			end
		end
	end

	// Read mux; unmapped offsets answer zero so probing software sees nothing
	always_comb begin
		rdata_next  = rdata_reg;
		rvalid_next = cfg_rd_in;
		if (cfg_rd_in) begin
			if (cfg_addr_in == CBWD_OFS_COMMAND) begin
				rdata_next = cmd_reg;
			end else if (cfg_addr_in == CBWD_OFS_MEM0_BOTTOM) begin
				rdata_next = mem_bottom_reg[0];
			end else if (cfg_addr_in == CBWD_OFS_MEM1_BOTTOM) begin
				rdata_next = mem_bottom_reg[1];
			end else if (cfg_addr_in == CBWD_OFS_MEM0_TOP) begin
				rdata_next = mem_top_reg[0] & CBWD_MEM_WMASK;
			end else if (cfg_addr_in == CBWD_OFS_MEM1_TOP) begin
				rdata_next = mem_top_reg[1] & CBWD_MEM_WMASK;
			end else if (cfg_addr_in == CBWD_OFS_IO0_BOTTOM) begin
				rdata_next = io_bottom_reg[0] & CBWD_IO_WMASK;
			end else if (cfg_addr_in == CBWD_OFS_IO1_BOTTOM) begin
				rdata_next = io_bottom_reg[1] & CBWD_IO_WMASK;
			end else if (cfg_addr_in == CBWD_OFS_IO0_TOP) begin
				rdata_next = io_top_reg[0] & CBWD_IO_WMASK;
			end else if (cfg_addr_in == CBWD_OFS_IO1_TOP) begin
				rdata_next = io_top_reg[1] & CBWD_IO_WMASK;
			end else begin
				rdata_next = 32'h0000_0000;
			end
		end
	end

	// Read answer registers
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg  <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Decode answer; window 0 wins if software overlaps the two windows
	always_comb begin
		ans_next    = '0;
		avalid_next = req_in.valid;
		if (req_in.valid) begin
			ans_next.is_io = req_in.is_io;
			if (mem_hit[0] || io_hit[0]) begin
				ans_next.claim  = 1'b1;
				ans_next.window = 1'b0;
			end else if (mem_hit[1] || io_hit[1]) begin
				ans_next.claim  = 1'b1;
				ans_next.window = 1'b1;
			end
		end
	end

	// Answers are registered so the claim lands one clock after the request
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ans_reg    <= '0;
			avalid_reg <= 1'b0;
		end else begin
			ans_reg    <= ans_next;
			avalid_reg <= avalid_next;
		end
	end

	assign cfg_rdata_out  = rdata_reg;
	assign cfg_rvalid_out = rvalid_reg;
	assign ans_out        = ans_reg;
	assign ans_valid_out  = avalid_reg;

endmodule : cbwd_window_decoder

// ### hdl/cbwd_pkg.sv
/*
 * Constants, types and helpers shared by the socket window decoder.
 * Assumes a 32-bit configuration access port and a 32-bit primary address.
 */
package cbwd_pkg;

	// Configuration offsets (byte addresses)
	localparam logic [7:0] CBWD_OFS_COMMAND      = 8'h04;
	localparam logic [7:0] CBWD_OFS_MEM0_BOTTOM  = 8'h1C;
	localparam logic [7:0] CBWD_OFS_MEM0_TOP     = 8'h20;
	localparam logic [7:0] CBWD_OFS_MEM1_BOTTOM  = 8'h24;
	localparam logic [7:0] CBWD_OFS_MEM1_TOP     = 8'h28;
	localparam logic [7:0] CBWD_OFS_IO0_BOTTOM   = 8'h2C;
	localparam logic [7:0] CBWD_OFS_IO0_TOP      = 8'h30;
	localparam logic [7:0] CBWD_OFS_IO1_BOTTOM   = 8'h34;
	localparam logic [7:0] CBWD_OFS_IO1_TOP      = 8'h38;

	// Writable bit masks; all other bits read back as zero
	localparam logic [31:0] CBWD_CMD_WMASK = 32'h0000_0003;
	localparam logic [31:0] CBWD_MEM_WMASK = 32'hFFFF_F000;
	localparam logic [31:0] CBWD_IO_WMASK  = 32'h0000_FFFC;

	// Command register enable bit positions
	localparam int CBWD_CMD_IO_EN_BIT  = 0;
	localparam int CBWD_CMD_MEM_EN_BIT = 1;

	// Reset values
	localparam logic [31:0] CBWD_CMD_RST        = 32'h0000_0000;
	localparam logic [31:0] CBWD_MEM_BOTTOM_RST = 32'hFFFF_F000;
	localparam logic [31:0] CBWD_MEM_TOP_RST    = 32'h0000_0000;
	localparam logic [31:0] CBWD_IO_BOTTOM_RST  = 32'h0000_FFFC;
	localparam logic [31:0] CBWD_IO_TOP_RST     = 32'h0000_0000;

	// Bits forced to ones when forming an inclusive upper bound
	localparam logic [31:0] CBWD_MEM_TOP_ONES = 32'h0000_0FFF;
	localparam logic [15:0] CBWD_IO_TOP_ONES  = 16'h0003;
	// I/O cycles must have these address bits clear
	localparam logic [31:0] CBWD_IO_HIGH_MASK = 32'hFFFF_0000;

	localparam int CBWD_NUM_WIN = 2;

	// Primary cycle presented for decoding
	typedef struct packed {
		logic        valid;
		logic        is_io;
		logic [31:0] addr;
	} cbwd_req_s;

	// Decode answer
	typedef struct packed {
		logic claim;
		logic is_io;
		logic window;
	} cbwd_ans_s;

	// Byte-enable merge of a write limited to writable bits
	function automatic logic [31:0] cbwd_merge(
		input logic [31:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0]  be,
		input logic [31:0] wmask
	);
		logic [31:0] lane;
		lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
		return (old_val & ~lane) | (wdata & lane);
	endfunction : cbwd_merge

endpackage : cbwd_pkg

// ### test/cbwd_window_decoder_chk.sv
/* Port checker for the socket window decoder.
   Assumes it is bound to the decoder and sees only its ports. */
module cbwd_window_decoder_chk
	import cbwd_pkg::*;
(
	// Watched ports
	input wire logic        core_clk_in,
	input wire logic        rst_n_in,
	input wire logic        cfg_wr_in,
	input wire logic        cfg_rd_in,
	input wire logic [7:0]  cfg_addr_in,
	input wire logic [3:0]  cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	input wire logic [31:0] cfg_rdata_out,
	input wire logic        cfg_rvalid_out,
	input wire cbwd_req_s   req_in,
	input wire cbwd_ans_s   ans_out,
	input wire logic        ans_valid_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Reads of the window registers, split by kind
	sequence mem_rd;
		cfg_rd_in && cfg_addr_in inside {8'h1C, 8'h20, 8'h24, 8'h28};
	endsequence
	sequence io_rd;
		cfg_rd_in && cfg_addr_in inside {8'h2C, 8'h30, 8'h34, 8'h38};
	endsequence
	rd_answer_a: assert property (cfg_rd_in |=> cfg_rvalid_out)
		else $error("read not answered");
	rd_quiet_a: assert property (!cfg_rd_in |=> !cfg_rvalid_out)
		else $error("stray read valid");
	mem_low_zero_a: assert property (mem_rd |=> cfg_rdata_out[11:0] == 12'h000)
		else $error("memory low bits not zero");
	io_fixed_zero_a: assert property (io_rd |=>
		{cfg_rdata_out[31:16], cfg_rdata_out[1:0]} == 18'h0)
		else $error("I/O fixed bits not zero");
	dec_answer_a: assert property (req_in.valid |=> ans_valid_out)
		else $error("decode not answered");
	dec_quiet_a: assert property (!req_in.valid |=> !ans_valid_out && ans_out == '0)
		else $error("stray decode answer");
	io_high_a: assert property (req_in.valid && req_in.is_io
		&& req_in.addr[31:16] != 16'h0000 |=> !ans_out.claim)
		else $error("high I/O address claimed");
	claim_kind_a: assert property (req_in.valid |=> !ans_out.claim
		|| ans_out.is_io == $past(req_in.is_io))
		else $error("claim kind wrong");
	// An unclaimed answer never names a window
	unclaimed_win_a: assert property (ans_valid_out && !ans_out.claim |-> !ans_out.window)
		else $error("window set without claim");
endmodule : cbwd_window_decoder_chk

bind cbwd_window_decoder cbwd_window_decoder_chk u_chk (.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
	.cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
	.cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out), .req_in(req_in),
	.ans_out(ans_out), .ans_valid_out(ans_valid_out));

// ### test/cbwd_host_model.sv
/* Host side: configuration software and a primary bus master.
   Assumes callers wait for each operation to finish before the next. */
module cbwd_host_model
	import cbwd_pkg::*;
(
	// Clock
	input  wire logic        core_clk_in,
	// Driven towards the decoder
	output logic             cfg_wr_out,
	output logic             cfg_rd_out,
	output logic      [7:0]  cfg_addr_out,
	output logic      [3:0]  cfg_be_out,
	output logic      [31:0] cfg_wdata_out,
	output cbwd_req_s        req_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle at time zero
	initial begin
		{cfg_wr_out, cfg_rd_out, cfg_be_out, cfg_addr_out} = '0;
		cfg_wdata_out = 32'h0000_0000;
		req_out = '0;
	end
	// One strobe per call, held over one rising edge, released at the next falling edge
	task automatic op(input logic w, input logic r, input logic [7:0] a,
		input logic [3:0] b, input logic [31:0] d, input cbwd_req_s q);
		@(negedge core_clk_in);
		{cfg_wr_out, cfg_rd_out, cfg_addr_out, cfg_be_out, cfg_wdata_out} = {w, r, a, b, d};
		req_out = q;
		@(negedge core_clk_in);
		{cfg_wr_out, cfg_rd_out} = 2'b00;
		req_out.valid = 1'b0;
		// Released lines change so nothing reads as still held
		cfg_wdata_out = ~cfg_wdata_out;
		req_out.addr = ~req_out.addr;
	endtask : op
endmodule : cbwd_host_model

// ### test/tb.sv
/* Self-checking bench for the window decoder.
   Assumes the host model drives every decoder input except clock and reset. */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cbwd_pkg::*;
	logic        core_clk_in, rst_n_in, wr, rd, rv, av;
	logic [7:0]  a8;
	logic [3:0]  be;
	logic [31:0] wd, rdat, sh [16];
	cbwd_req_s   q;
	cbwd_ans_s   ans;
	int          n_mismatch, checks_done, seed;
	logic [31:0] mc [4] = '{32'h0FFF_FFFF, 32'h1000_0000, 32'h1000_0FFF, 32'h1000_1000};
	logic [31:0] ic [5] = '{32'h1233, 32'h1234, 32'h1237, 32'h1238, 32'h0001_1234};
	cbwd_host_model h (.core_clk_in(core_clk_in), .cfg_wr_out(wr), .cfg_rd_out(rd),
		.cfg_addr_out(a8), .cfg_be_out(be), .cfg_wdata_out(wd), .req_out(q));
	cbwd_window_decoder DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cfg_wr_in(wr),
		.cfg_rd_in(rd), .cfg_addr_in(a8), .cfg_be_in(be), .cfg_wdata_in(wd),
		.cfg_rdata_out(rdat), .cfg_rvalid_out(rv), .req_in(q), .ans_out(ans), .ans_valid_out(av));
	// 50 MHz clock
	initial begin
		core_clk_in = 1'b0;
		forever #10 core_clk_in = ~core_clk_in;
	end
	// Wide enough for a valid flag above a full data word
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Writable bits per offset; unmapped offsets hold nothing
	function automatic logic [31:0] wm(input logic [7:0] o);
		case (o)
			8'h04: return 32'h0000_0003;
			8'h1C, 8'h20, 8'h24, 8'h28: return 32'hFFFF_F000;
			8'h2C, 8'h30, 8'h34, 8'h38: return 32'h0000_FFFC;
			default: return 32'h0000_0000;
		endcase
	endfunction : wm
	// Expected {claim, kind, window}; window 0 wins when both hit
	function automatic logic [2:0] exp_ans(input cbwd_req_s r);
		logic [31:0] lo, hi;
		logic [2:0]  e;
		e = 3'b000;
		for (int w = 1; w >= 0; w--) begin
			lo = r.is_io ? sh[11 + 2 * w] : sh[7 + 2 * w];
			hi = r.is_io ? sh[12 + 2 * w] | 32'h3 : sh[8 + 2 * w] | 32'hFFF;
			if (sh[1][!r.is_io] && !(r.is_io && r.addr[31:16] != 16'h0) && r.addr >= lo
				&& r.addr <= hi) e = {1'b1, r.is_io, w[0]};
		end
		return e;
	endfunction : exp_ans
	task automatic wr_reg(input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
		logic [31:0] m;
		m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & wm(o);
		h.op(1'b1, 1'b0, o, b, d, '0);
		sh[o[5:2]] = (sh[o[5:2]] & ~m) | (d & m);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] o);
		h.op(1'b0, 1'b1, o, 4'h0, 32'h0, '0);
		chk({rv, rdat}, {1'b1, sh[o[5:2]]});
	endtask : rd_reg
	task automatic dec(input logic io, input logic [31:0] ad);
		cbwd_req_s r;
		r = {1'b1, io, ad};
		h.op(1'b0, 1'b0, 8'h00, 4'h0, 32'h0, r);
		chk({av, ans.claim, ans.is_io & ans.claim, ans.window}, {1'b1, exp_ans(r)});
	endtask : dec
	task automatic sweep();
		foreach (mc[i]) dec(1'b0, mc[i]);
		foreach (ic[i]) dec(1'b1, ic[i]);
	endtask : sweep
	// Reset held for 8 clocks; shadow copy returns to the reset values
	task automatic do_reset();
		rst_n_in = 1'b0;
		sh = '{default: 32'h0};
		{sh[7], sh[9]} = {2{32'hFFFF_F000}};
		{sh[11], sh[13]} = {2{32'h0000_FFFC}};
		repeat (8) @(posedge core_clk_in);
		@(negedge core_clk_in);
		rst_n_in = 1'b1;
	endtask : do_reset
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// Main sequence: reset values, masks, corners, then random traffic
	initial begin
		seed = 85741;
		do_reset();
		for (int i = 0; i < 16; i++) rd_reg(8'(4 * i));
		for (int i = 0; i < 16; i++) begin
			wr_reg(8'(4 * i), 4'hF, 32'hFFFF_FFFF);
			rd_reg(8'(4 * i));
		end
		wr_reg(8'h1C, 4'hF, 32'h1000_0000);
		wr_reg(8'h20, 4'hF, 32'h1000_0000);
		wr_reg(8'h2C, 4'hF, 32'h0000_1234);
		wr_reg(8'h30, 4'hF, 32'h0000_1234);
		for (int k = 3; k >= 0; k--) begin
			wr_reg(8'h04, 4'h1, 32'(k));
			sweep();
		end
		// Software turns windows off by lowering their tops
		wr_reg(8'h20, 4'hF, 32'h0FFF_F000);
		wr_reg(8'h30, 4'hF, 32'h0000_1230);
		wr_reg(8'h04, 4'hF, 32'h0000_0003);
		sweep();
		// Reset in mid-run must bring every register back to its reset value
		do_reset();
		for (int i = 0; i < 16; i++) rd_reg(8'(4 * i));
		sweep();
		repeat (300) begin
			case ($unsigned($random(seed)) % 3)
				0: wr_reg(8'($unsigned($random(seed)) % 16 * 4), 4'($random(seed)), $random(seed));
				1: rd_reg(8'($unsigned($random(seed)) % 16 * 4));
				default: dec(1'($random(seed)), $random(seed) & 32'h1001_FFFF);
			endcase
		end
		wrap_up();
	end
	// Hang guard
	initial begin
		#400000;
		n_mismatch++;
		wrap_up();
	end
endmodule : tb
